// file: src/rcim_top.sv
// interrupt mask, raw and masked status, acknowledge and capability word of the radio core
`timescale 1ns/1ps
`include "rcim_regs.svh"

// How it works
// - capability bits 29:24 read the address width value 0x10
// - capability bits 13:8 read core MHz from strap, zero after reset
// - capability bit 4 reads 1; pending flags stay high until acknowledged
// - capability bits 3..0 read 1: wlan, diag port, ccm engine, 32-bit bus
// - capability bits 5 and 6 read 0: standalone, no decrypt unit
// - mask bit 15 lets the tick interrupt set during events; resets to 1
// - mask bits 9..0 each gate their own source onto status and irq
// - mask resets with bits 15,8,4..0 set; bits 14:10 read 0
// - sources 9..5: software, event/prefetch abort, fine, gross timer, fault
// - sources 4..0: cipher done, event end, wake, packet rx, tick
// - status bit is raw pending and mask; read only, zero at reset
// - status bit 0 is the 625 us base time tick
// - status bit 3 is end of advertising, scanning or connection event
// - status bit 4 is end of an encrypt or decrypt operation
// - status bit 2 is leaving sleep mode
// - writing 1 to an acknowledge bit clears raw and masked; reads 0
// - raw status word shows pending state regardless of mask
// - writing 1 to control bit 28 raises the software interrupt
module rcim_top #(
  // arbitrary value, not tied to any real radio interface
  parameter logic [6:0] RADIO_IF_ID = 7'h05
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_ce,
  input  wire rcim_pkg::rcim_bus_req_type i_bus,
  input  wire rcim_pkg::rcim_hw_evt_type  i_hw_evt,
  input  wire logic                      i_in_event,
  input  wire logic [5:0]                i_core_mhz,
  output logic [31:0]                    o_rdata,
  output logic                           o_irq
);
  import rcim_pkg::*;

  rcim_irq_vec_type raw_q;
  rcim_irq_vec_type set_vec;
  rcim_irq_vec_type clr_vec;
  rcim_irq_vec_type stat_vec;
  logic [15:0]      mask_q;
  logic [15:0]      mask_d;
  logic [5:0]       mhz_sync;
  logic [5:0]       mhz_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             irq_q;
  logic             irq_d;

  // ---------------- address decode ----------------
  wire sel_ctl  = (i_bus.addr == `RCIM_CTL_OFS);
  wire sel_cap  = (i_bus.addr == `RCIM_CAP_OFS);
  wire sel_mask = (i_bus.addr == `RCIM_MASK_OFS);
  wire sel_stat = (i_bus.addr == `RCIM_STAT_OFS);
  wire sel_raw  = (i_bus.addr == `RCIM_RAW_OFS);
  wire sel_ack  = (i_bus.addr == `RCIM_ACK_OFS);

  wire wr_ctl   = i_bus.wr & sel_ctl;
  wire wr_mask  = i_bus.wr & sel_mask;
  wire wr_ack   = i_bus.wr & sel_ack;

  // ---------------- strap for the frequency field ----------------
  // the strap is a pin level, so it is synchronised before use
  rcim_sync #(
    .WIDTH (6)
  ) u_mhz_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .i_d    (i_core_mhz),
    .o_q    (mhz_sync)
  );

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      mhz_q <= `RCIM_CAP_MHZ_RST;
    else if (i_ce)
      mhz_q <= mhz_sync;
  end

  // ---------------- mask register ----------------
  // only bits 15 and 9..0 take write data; 14:10 stay zero
  assign mask_d = wr_mask ? (i_bus.wdata[15:0] & `RCIM_MASK_WMASK) : mask_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      mask_q <= `RCIM_MASK_RST;
    else if (i_ce)
      mask_q <= mask_d;
  end

  // ---------------- pending flags ----------------
  // tick may be blocked while the core runs an event
  wire tick_allowed = ~i_in_event | mask_q[`RCIM_MASK_EVT_BIT];
  wire soft_force   = wr_ctl & i_bus.wdata[`RCIM_CTL_FORCE_BIT];

  // positions: 9 soft, 8 abort, 7 fine, 6 gross, 5 fault,
  // 4 cipher, 3 event end, 2 wake, 1 rx, 0 tick
  assign set_vec = {soft_force,
                    i_hw_evt[8:1],
                    i_hw_evt[0] & tick_allowed};

  assign clr_vec = wr_ack ? i_bus.wdata[9:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < `RCIM_NUM_SRC; gi++)
    begin : g_flag
      // level style: stays set until acknowledged
      rcim_pend_flag u_flag (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_ce   (i_ce),
        .i_set  (set_vec[gi]),
        .i_clr  (clr_vec[gi]),
        .o_q    (raw_q[gi])
      );
    end
  endgenerate

  // masked status is derived, so an acknowledge clears it with the raw flag
  assign stat_vec = raw_q & mask_q[9:0];

  // ---------------- interrupt output ----------------
  // one cycle behind the status word, as the output must come from a flop
  assign irq_d = |stat_vec;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      irq_q <= 1'b0;
    else if (i_ce)
      irq_q <= irq_d;
  end

  // ---------------- read path ----------------
  wire [31:0] cap_word = {2'b00,
                          `RCIM_CAP_AW_VAL,
                          1'b0,
                          RADIO_IF_ID,
                          2'b00,
                          mhz_q,
                          1'b0,
                          `RCIM_CAP_FLAGS_VAL};

  wire [31:0] mask_word = {16'h0000, mask_q};
  wire [31:0] stat_word = {22'h00_0000, stat_vec};
  wire [31:0] raw_word  = {22'h00_0000, raw_q};

  // control and acknowledge bits are write-only pulses and read zero
  assign rdata_d = !i_bus.rd ? `RCIM_RDATA_ZERO :
                   sel_cap   ? cap_word :
                   sel_mask  ? mask_word :
                   sel_stat  ? stat_word :
                   sel_raw   ? raw_word :
                   `RCIM_RDATA_ZERO;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= `RCIM_RDATA_ZERO;
    else if (i_ce)
      rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;
  assign o_irq   = irq_q;

  // ---------------- assertions ----------------
  AST_CAP_CONST: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_cap)
    |=> (o_rdata[31:24] == 8'h10) && (o_rdata[23] == 1'b0)
  ) else $error("address width field of capability word is wrong");

  AST_CAP_FLAGS: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_cap)
    |=> (o_rdata[7:0] == 8'h1F) && (o_rdata[15:14] == 2'b00)
  ) else $error("capability flag bits are wrong");

  AST_CAP_MHZ: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_cap)
    |=> (o_rdata[13:8] == $past(mhz_q))
  ) else $error("frequency field does not follow the strap");

  AST_MASK_READBACK: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && wr_mask) ##1 (i_ce && i_bus.rd && sel_mask)
    |=> (o_rdata == ({16'h0000, $past(i_bus.wdata[15:0], 2)} & 32'h0000_83FF))
  ) else $error("mask readback differs from written value");

  AST_STAT_GATED: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_stat)
    |=> (o_rdata == {22'h00_0000, $past(raw_q) & $past(mask_q[9:0])})
  ) else $error("status read is not raw and mask");

  AST_ACK_CLEARS: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && wr_ack && (i_bus.wdata[9:0] == 10'h3FF) && (i_hw_evt == 9'h000))
    |=> (raw_q == 10'h000) ##1 (!$past(i_ce) || (o_irq == 1'b0) || (raw_q != 10'h000))
  ) else $error("acknowledge left a pending flag set");

  AST_SET_BEATS_ACK: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_hw_evt[1] && wr_ack && i_bus.wdata[1])
    |=> raw_q[1]
  ) else $error("event lost in acknowledge cycle");

  AST_LEVEL_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && raw_q[5] && !(wr_ack && i_bus.wdata[5]))
    |=> raw_q[5]
  ) else $error("pending flag dropped without acknowledge");

  AST_SOFT_FORCE: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && soft_force && mask_q[9] && !wr_mask)
    |=> raw_q[9] ##1 (!$past(i_ce) || o_irq)
  ) else $error("software force did not raise the interrupt");

  AST_TICK_BLOCK: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_event && !mask_q[15] && !raw_q[0])
    |=> !raw_q[0]
  ) else $error("tick set during an event while blocked");

  AST_IRQ_FOLLOWS: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_ce |=> (o_irq == $past(|(raw_q & mask_q[9:0])))
  ) else $error("irq output does not follow masked status");

  AST_RO_IGNORED: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.wr && (sel_stat || sel_cap || sel_raw))
    |=> $stable(mask_q)
  ) else $error("write to read only word changed the mask");

  AST_RDATA_IDLE: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_bus.rd) |=> (o_rdata == 32'h0000_0000)
  ) else $error("read data not zero outside a read answer");

  AST_CAP_LEVEL: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_cap)
    |=> (o_rdata[4] == 1'b1)
  ) else $error("level interrupt flag of capability word is not set");

  AST_CAP_STANDALONE: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_cap)
    |=> (o_rdata[6:5] == 2'b00)
  ) else $error("standalone or decrypt flag of capability word is set");

  AST_MASK_RSVD: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_mask)
    |=> (o_rdata[31:16] == 16'h0000) && (o_rdata[14:10] == 5'h00)
  ) else $error("reserved mask bits do not read zero");

  AST_MASK_GATES: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_stat && (mask_q[9:0] == 10'h000))
    |=> (o_rdata == 32'h0000_0000)
  ) else $error("status shows a source whose mask bit is clear");

  AST_RAW_READ: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && sel_raw)
    |=> (o_rdata == {22'h00_0000, $past(raw_q)})
  ) else $error("raw status read does not show the pending flags");

  AST_EVT_SETS: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && (i_hw_evt[8:1] != 8'h00))
    |=> ((raw_q[8:1] & $past(i_hw_evt[8:1])) == $past(i_hw_evt[8:1]))
  ) else $error("hardware event did not set its pending flag");

  AST_TICK_SETS: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_hw_evt[0] && (!i_in_event || mask_q[15]))
    |=> raw_q[0]
  ) else $error("allowed tick did not set its pending flag");

  AST_WO_READ_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && (sel_ctl || sel_ack))
    |=> (o_rdata == 32'h0000_0000)
  ) else $error("write only word does not read zero");

  AST_UNLISTED_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_bus.rd && (sel_stat || sel_raw))
    |=> (o_rdata[31:10] == 22'h00_0000)
  ) else $error("unlisted status bits do not read zero");

  AST_ACK_ONE: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && wr_ack && i_bus.wdata[2] && !i_hw_evt[2])
    |=> !raw_q[2]
  ) else $error("acknowledge of the wake flag did not clear it");
endmodule

// file: inc/rcim_regs.svh
// register offsets, field positions, reset values and constant words of the irq block
`ifndef RCIM_REGS_SVH
`define RCIM_REGS_SVH

// byte addresses on the register port
`define RCIM_CTL_OFS         32'h4000_0000
`define RCIM_CAP_OFS         32'h4000_0008
`define RCIM_MASK_OFS        32'h4000_000C
`define RCIM_STAT_OFS        32'h4000_0010
`define RCIM_RAW_OFS         32'h4000_0014
`define RCIM_ACK_OFS         32'h4000_0018

// number of interrupt sources and their positions
`define RCIM_NUM_SRC         10
`define RCIM_SRC_SOFT        9
`define RCIM_SRC_TICK        0

// capability word fields
`define RCIM_CAP_AW_HI       29
`define RCIM_CAP_AW_LO       24
`define RCIM_CAP_AW_VAL      6'h10
`define RCIM_CAP_ID_HI       22
`define RCIM_CAP_ID_LO       16
`define RCIM_CAP_MHZ_HI      13
`define RCIM_CAP_MHZ_LO      8
`define RCIM_CAP_MHZ_RST     6'h00
`define RCIM_CAP_FLAGS_HI    6
`define RCIM_CAP_FLAGS_LO    0
// bits 6..0: no decrypt unit, standalone, level irq, wlan, diag, ccm, 32-bit bus
`define RCIM_CAP_FLAGS_VAL   7'h1F

// mask word
`define RCIM_MASK_EVT_BIT    15
`define RCIM_MASK_RST        16'h811F
`define RCIM_MASK_WMASK      16'h83FF

// control word: software interrupt force bit
`define RCIM_CTL_FORCE_BIT   28

`define RCIM_RDATA_ZERO      32'h0000_0000
`endif

// file: inc/rcim_pkg.sv
// types shared by the irq mask/status block
package rcim_pkg;

  // one register port request, sampled on the rising clock edge
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rcim_bus_req_type;

  // one bit per interrupt source
  typedef logic [9:0] rcim_irq_vec_type;

  // hardware event sources, bit 9 (software) excluded
  typedef logic [8:0] rcim_hw_evt_type;

endpackage

// file: src/rcim_sync.sv
// two-flop synchroniser for a static strap vector
`timescale 1ns/1ps
module rcim_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // the first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (i_ce)
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule

// file: src/rcim_pend_flag.sv
// one sticky pending flag: set wins over clear
`timescale 1ns/1ps
module rcim_pend_flag (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_q
);
  logic flag_q;
  logic flag_d;

  // an event landing in the acknowledge cycle must not be lost
  assign flag_d = i_set | (flag_q & ~i_clr);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      flag_q <= 1'b0;
    else if (i_ce)
      flag_q <= flag_d;
  end

  assign o_q = flag_q;
endmodule

// file: tb/rcim_cpu_model.sv
// processor side of the register port: one-cycle read and write strobes
`timescale 1ns/1ps
module rcim_cpu_model (
  input  wire logic                   i_clk,
  input  wire logic [31:0]            i_rdata,
  output rcim_pkg::rcim_bus_req_type  o_bus
);
  import rcim_pkg::*;

  initial o_bus = '0;

  // software sets an acknowledge or force bit by writing 1
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clk);
    o_bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(posedge i_clk);
    o_bus <= '0;
    // taken at the edge that closes the answer cycle
    @(posedge i_clk);
    d = i_rdata;
  endtask

  // a write followed with no gap by a read, as the port allows
  task automatic wr_rd(input logic [31:0] wa, input logic [31:0] wd,
                       input logic [31:0] ra, output logic [31:0] d);
    @(posedge i_clk);
    o_bus <= '{rd: 1'b0, wr: 1'b1, addr: wa, wdata: wd};
    @(posedge i_clk);
    o_bus <= '{rd: 1'b1, wr: 1'b0, addr: ra, wdata: 32'h0000_0000};
    @(posedge i_clk);
    o_bus <= '0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule

// file: tb/radio_core_irq_mask_status_bench.sv
// self-checking bench of the irq mask, status and capability block
`timescale 1ns/1ps
`include "rcim_regs.svh"
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
    end \
  end
module radio_core_irq_mask_status_bench;
  import rcim_pkg::*;
  typedef struct packed {
    logic [8:0]  evt;
    logic [15:0] mask;
    logic        in_ev;
    logic [9:0]  raw;
    logic [9:0]  stat;
  } rcimb_row_type;
  // arbitrary interface id
  localparam logic [6:0]  RIF     = 7'h33;
  localparam logic [31:0] CAP_EXP = {2'b00, 6'h10, 1'b0, RIF, 2'b00, 6'h2D, 1'b0, 7'h1F};
  // the frequency field still reads zero just after reset
  localparam logic [31:0] CAP_RST = {2'b00, 6'h10, 1'b0, RIF, 2'b00, 6'h00, 1'b0, 7'h1F};
  logic             i_clk;
  logic             i_nrst;
  logic             i_ce;
  logic             i_in_event;
  logic [8:0]       i_hw_evt;
  logic [5:0]       i_core_mhz;
  rcim_bus_req_type i_bus;
  logic [31:0]      o_rdata;
  logic             o_irq;
  logic [31:0]      rd_word;
  int               miscompares = 0;
  int               tests_run = 0;
  rcimb_row_type rows [9] = '{
    '{9'h001, 16'h0001, 1'b0, 10'h001, 10'h001},
    '{9'h001, 16'h0001, 1'b1, 10'h000, 10'h000},
    '{9'h001, 16'h8001, 1'b1, 10'h001, 10'h001},
    '{9'h002, 16'h0002, 1'b0, 10'h002, 10'h002},
    '{9'h004, 16'h0000, 1'b0, 10'h004, 10'h000},
    '{9'h008, 16'h0008, 1'b0, 10'h008, 10'h008},
    '{9'h010, 16'h0010, 1'b0, 10'h010, 10'h010},
    '{9'h1E0, 16'h03E0, 1'b0, 10'h1E0, 10'h1E0},
    '{9'h1FF, 16'h0000, 1'b0, 10'h1FF, 10'h000}
  };

  rcim_top #(.RADIO_IF_ID(RIF)) rcim_top_inst (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_bus      (i_bus),
    .i_hw_evt   (i_hw_evt),
    .i_in_event (i_in_event),
    .i_core_mhz (i_core_mhz),
    .o_rdata    (o_rdata),
    .o_irq      (o_irq)
  );

  rcim_cpu_model rcim_cpu_model_inst (
    .i_clk   (i_clk),
    .i_rdata (o_rdata),
    .o_bus   (i_bus)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_rd(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    rcim_cpu_model_inst.rd(a, d);
    `CHK(n, e, d)
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
  endtask

  // a hang is cut short here rather than left to run
  initial
  begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    i_nrst     = 1'b0;
    i_ce       = 1'b1;
    i_in_event = 1'b0;
    i_hw_evt   = '0;
    i_core_mhz = 6'h2D;
    do_reset();
    foreach (rows[i])
    begin
      rcim_cpu_model_inst.wr(`RCIM_MASK_OFS, {16'h0000, rows[i].mask});
      @(posedge i_clk);
      i_in_event <= rows[i].in_ev;
      i_hw_evt   <= rows[i].evt;
      @(posedge i_clk);
      i_hw_evt   <= '0;
      i_in_event <= 1'b0;
      // flags must stay up with no further events
      repeat (3) @(posedge i_clk);
      chk_rd("raw", `RCIM_RAW_OFS, {22'h0, rows[i].raw});
      chk_rd("status", `RCIM_STAT_OFS, {22'h0, rows[i].stat});
      `CHK("irq", |rows[i].stat, o_irq)
      rcim_cpu_model_inst.wr(`RCIM_ACK_OFS, 32'h0000_03FF);
      chk_rd("raw after ack", `RCIM_RAW_OFS, 32'h0);
      `CHK("irq after ack", 1'b0, o_irq)
    end
    // an event in the acknowledge cycle must survive it; flags stay for the reset
    rcim_cpu_model_inst.wr(`RCIM_MASK_OFS, 32'h0000_03FF);
    fork
      rcim_cpu_model_inst.wr(`RCIM_ACK_OFS, 32'h0000_0002);
      begin
        @(posedge i_clk);
        i_hw_evt <= 9'h1FF;
        @(posedge i_clk);
        i_hw_evt <= 9'h000;
      end
    join
    chk_rd("set beats ack", `RCIM_RAW_OFS, 32'h0000_01FF);
    `CHK("irq pending", 1'b1, o_irq)
    // mid-run reset must restore every reset value
    do_reset();
    `CHK("irq reset", 1'b0, o_irq)
    chk_rd("cap after reset", `RCIM_CAP_OFS, CAP_RST);
    chk_rd("raw reset", `RCIM_RAW_OFS, 32'h0);
    chk_rd("mask reset", `RCIM_MASK_OFS, 32'h0000_811F);
    chk_rd("status reset", `RCIM_STAT_OFS, 32'h0);
    chk_rd("cap", `RCIM_CAP_OFS, CAP_EXP);
    rcim_cpu_model_inst.wr(`RCIM_CAP_OFS, 32'hFFFF_FFFF);
    rcim_cpu_model_inst.wr(`RCIM_STAT_OFS, 32'hFFFF_FFFF);
    chk_rd("cap kept", `RCIM_CAP_OFS, CAP_EXP);
    chk_rd("status kept", `RCIM_STAT_OFS, 32'h0);
    // write and read back to back, with no idle cycle between
    rcim_cpu_model_inst.wr_rd(`RCIM_MASK_OFS, 32'hFFFF_FFFF, `RCIM_MASK_OFS, rd_word);
    `CHK("mask bits", 32'h0000_83FF, rd_word)
    chk_rd("unmapped", 32'h4000_0004, 32'h0);
    rcim_cpu_model_inst.wr(`RCIM_CTL_OFS, 32'h1000_0000);
    chk_rd("soft raw", `RCIM_RAW_OFS, 32'h0000_0200);
    chk_rd("soft status", `RCIM_STAT_OFS, 32'h0000_0200);
    `CHK("soft irq", 1'b1, o_irq)
    chk_rd("ctl reads 0", `RCIM_CTL_OFS, 32'h0);
    chk_rd("ack reads 0", `RCIM_ACK_OFS, 32'h0);
    rcim_cpu_model_inst.wr(`RCIM_ACK_OFS, 32'h0000_0200);
    chk_rd("soft cleared", `RCIM_STAT_OFS, 32'h0);
    // with the clock enable low a write must not land
    @(posedge i_clk);
    i_ce <= 1'b0;
    rcim_cpu_model_inst.wr(`RCIM_MASK_OFS, 32'h0000_0000);
    i_ce <= 1'b1;
    chk_rd("mask frozen", `RCIM_MASK_OFS, 32'h0000_83FF);
    finish_test();
  end
endmodule
